// >>> hw/call_return_reset_exec.sv
// Execution of software reset, relative call and the two return instructions.
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "call_return_reset_exec_regs.svh"

module call_return_reset_exec #(
	parameter int PC_W        = 21,
	parameter int STACK_DEPTH = 31
) (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rst,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Execution state.
	output logic             busy,
	output call_return_reset_exec_pkg::state_type state
);
	import call_return_reset_exec_pkg::*;

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [PC_W-1:0] stack_q [STACK_DEPTH];
	logic [4:0]      ptr_q;
	logic [PC_W-1:0] pc_q;
	logic [PC_W-1:0] target_q;
	logic [7:0]      work_q;
	logic [7:0]      flags_q;
	logic [3:0]      bank_q;
	logic [7:0]      working_shadow_q;
	logic [7:0]      flags_shadow_q;
	logic [3:0]      bank_select_shadow_q;
	logic [7:0]      pc_latch_high_q;
	logic [4:0]      pc_latch_upper_q;
	logic            global_high_irq_enable_q;
	logic            low_priority_irq_enable_q;
	state_type       state_q;
	logic [1:0]      phase_q;
	op_type          op_q;
	logic            fast_q;
	logic            high_q;
	logic [7:0]      lit_q;
	logic [31:0]     prdata_q;

	function automatic logic [PC_W-1:0] next_word(input logic [PC_W-1:0] a);
		next_word = a + PC_W'(`CRX_PC_STEP);
	endfunction

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	wire             acc       = psel & penable;
	wire             wr        = acc & pwrite;
	wire             idle      = (state_q == ST_IDLE);
	wire             hit_ctrl  = (paddr == `CRX_OFF_CTRL);
	wire             hit_pc    = (paddr == `CRX_OFF_PC);
	wire             hit_tgt   = (paddr == `CRX_OFF_TARGET);
	wire             hit_core  = (paddr == `CRX_OFF_CORE);
	wire             hit_shd   = (paddr == `CRX_OFF_SHADOW);
	wire             hit_latch = (paddr == `CRX_OFF_LATCH);
	wire             hit_stack = (paddr == `CRX_OFF_STACK);
	wire             mapped    = hit_ctrl | hit_pc | hit_tgt | hit_core
	                           | hit_shd | hit_latch | hit_stack;
	// Writes to state are refused while an instruction runs.
	wire             wr_ok     = wr & mapped & idle & ~hit_stack;
	wire [2:0]       wop       = pwdata[`CRX_CTRL_OP_LSB +: 3];
	wire             issue     = wr_ok & hit_ctrl & (wop >= 3'(OP_RESET))
	                           & (wop <= 3'(OP_RETURN_WITH_LITERAL));
	wire             in_exec1  = (state_q == ST_EXEC1);
	wire             two_cyc   = (op_q != OP_RESET);
	wire             do_reset  = in_exec1 & (op_q == OP_RESET)
	                           & (phase_q == `CRX_PHASE_RESET);
	wire             do_push   = in_exec1 & (op_q == OP_RELATIVE_SUBROUTINE_CALL)
	                           & (phase_q == `CRX_PHASE_PUSH);
	wire             at_last   = (phase_q == `CRX_PHASE_LAST);
	wire             do_jump   = in_exec1 & (op_q == OP_RELATIVE_SUBROUTINE_CALL) & at_last;
	wire             do_return_from_irq = in_exec1 & (op_q == OP_RETURN_FROM_IRQ) & at_last;
	wire             do_return_with_literal  = in_exec1 & (op_q == OP_RETURN_WITH_LITERAL) & at_last;
	wire             do_pop    = do_return_from_irq | do_return_with_literal;
	wire [PC_W-1:0]  top_of_return_stack       = (ptr_q == 5'h00) ? PC_W'(0)
	                           : stack_q[ptr_q - 5'h01];
	wire             can_push  = (ptr_q < 5'(STACK_DEPTH));
	wire [31:0]      rd_mux    = hit_ctrl  ? {31'h0000_0000, busy}
	                           : hit_pc    ? 32'(pc_q)
	                           : hit_tgt   ? 32'(target_q)
	                           : hit_core  ? {12'h000, bank_q, flags_q, work_q}
	                           : hit_shd   ? {12'h000, bank_select_shadow_q,
	                                          flags_shadow_q, working_shadow_q}
	                           : hit_latch ? {14'h0000,
	                                          low_priority_irq_enable_q,
	                                          global_high_irq_enable_q, 3'h0,
	                                          pc_latch_upper_q, pc_latch_high_q}
	                           : hit_stack ? {3'h0, ptr_q, 3'h0, top_of_return_stack}
	                           : 32'h0000_0000;

	assign pready  = 1'b1;
	assign prdata  = prdata_q;
	assign pslverr = acc & (~mapped | (pwrite & ~idle) | (pwrite & hit_stack));
	assign busy    = ~idle;
	assign state   = state_q;

	// Read data is captured in the setup cycle so that it leaves a flop.
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			prdata_q <= 32'h0000_0000;
		else if (psel && !penable)
			prdata_q <= rd_mux;
	end

	// ------------------------------------------------------------
	// Sequencer: one instruction cycle is four clocks
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_IDLE;
			phase_q <= 2'h0;
			op_q    <= OP_NONE;
			fast_q  <= 1'b0;
			high_q  <= 1'b0;
			lit_q   <= 8'h00;
		end else begin
			phase_q <= idle ? 2'h0 : phase_q + 2'h1;
			case (state_q)
				ST_IDLE: begin
					if (issue) begin
						state_q <= ST_EXEC1;
						op_q    <= op_type'(wop);
						fast_q  <= pwdata[`CRX_CTRL_FAST_BIT];
						high_q  <= pwdata[`CRX_CTRL_HIGH_BIT];
						lit_q   <= pwdata[`CRX_CTRL_LIT_LSB +: 8];
					end
				end
				ST_EXEC1: begin
					if (at_last)
						state_q <= two_cyc ? ST_EXEC2 : ST_IDLE;
				end
				ST_EXEC2: begin
					if (at_last)
						state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Return stack
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (do_push && can_push)
			stack_q[ptr_q] <= next_word(pc_q);
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			ptr_q <= `CRX_RST_PTR;
		else if (do_reset)
			ptr_q <= `CRX_RST_PTR;
		else if (do_push && can_push)
			ptr_q <= ptr_q + 5'h01;
		else if (do_pop && ptr_q != 5'h00)
			ptr_q <= ptr_q - 5'h01;
	end

	// ------------------------------------------------------------
	// Core registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst || do_reset) begin
			pc_q                      <= PC_W'(`CRX_RST_PC);
			target_q                  <= PC_W'(`CRX_RST_PC);
			work_q                    <= `CRX_RST_WORK;
			flags_q                   <= `CRX_RST_FLAGS;
			bank_q                    <= `CRX_RST_BANK;
			working_shadow_q          <= `CRX_RST_WORK;
			flags_shadow_q            <= `CRX_RST_FLAGS;
			bank_select_shadow_q      <= `CRX_RST_BANK;
			pc_latch_high_q           <= `CRX_RST_LATCH_HI;
			pc_latch_upper_q          <= `CRX_RST_LATCH_UP;
			global_high_irq_enable_q  <= `CRX_RST_IRQ_EN;
			low_priority_irq_enable_q <= `CRX_RST_IRQ_EN;
		end else if (do_jump) begin
			pc_q <= target_q;
		end else if (do_return_from_irq) begin
			pc_q <= top_of_return_stack;
			if (high_q)
				global_high_irq_enable_q <= 1'b1;
			else
				low_priority_irq_enable_q <= 1'b1;
			if (fast_q) begin
				work_q  <= working_shadow_q;
				flags_q <= flags_shadow_q;
				bank_q  <= bank_select_shadow_q;
			end
		end else if (do_return_with_literal) begin
			pc_q   <= top_of_return_stack;
			work_q <= lit_q;
		end else if (wr_ok) begin
			if (hit_pc)
				pc_q <= pwdata[PC_W-1:0];
			if (hit_tgt)
				target_q <= pwdata[PC_W-1:0];
			if (hit_core) begin
				work_q  <= pwdata[7:0];
				flags_q <= pwdata[`CRX_CORE_FLG_LSB +: 8];
				bank_q  <= pwdata[`CRX_CORE_BSR_LSB +: 4];
			end
			if (hit_shd) begin
				working_shadow_q     <= pwdata[7:0];
				flags_shadow_q       <= pwdata[`CRX_CORE_FLG_LSB +: 8];
				bank_select_shadow_q <= pwdata[`CRX_CORE_BSR_LSB +: 4];
			end
			if (hit_latch) begin
				pc_latch_high_q           <= pwdata[7:0];
				pc_latch_upper_q          <= pwdata[`CRX_LATCH_UP_LSB +: 5];
				global_high_irq_enable_q  <= pwdata[`CRX_LATCH_GIEH];
				low_priority_irq_enable_q <= pwdata[`CRX_LATCH_GIEL];
			end
		end
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_reset_clears;
		@(posedge clk) disable iff (rst)
		do_reset |=> (pc_q == '0) && (ptr_q == '0) && (work_q == '0)
			&& !global_high_irq_enable_q && !low_priority_irq_enable_q;
	endproperty
	a_reset_clears: assert property (p_reset_clears)
		else $error("software reset left state non-reset");
	property p_call_push;
		@(posedge clk) disable iff (rst)
		(do_push && can_push) |=> (top_of_return_stack == next_word($past(pc_q)))
			##2 (pc_q == $past(target_q, 3));
	endproperty
	a_call_push: assert property (p_call_push)
		else $error("relative call return address or target wrong");
	property p_pop_level;
		@(posedge clk) disable iff (rst)
		(do_return_from_irq && ptr_q != 5'h00) |=> (ptr_q == $past(ptr_q) - 5'h01);
	endproperty
	a_pop_level: assert property (p_pop_level)
		else $error("return did not pop one level");
	property p_pc_from_tos;
		@(posedge clk) disable iff (rst)
		do_return_from_irq |=> (pc_q == $past(top_of_return_stack));
	endproperty
	a_pc_from_tos: assert property (p_pc_from_tos)
		else $error("program counter not loaded from stack top");
	property p_irq_enable;
		@(posedge clk) disable iff (rst)
		do_return_from_irq |=> (high_q ? global_high_irq_enable_q
			: low_priority_irq_enable_q);
	endproperty
	a_irq_enable: assert property (p_irq_enable)
		else $error("interrupt enable not set on return");
	property p_fast_restore;
		@(posedge clk) disable iff (rst)
		do_return_from_irq |=> (work_q == ($past(fast_q) ? $past(working_shadow_q)
			: $past(work_q))) && (bank_q == ($past(fast_q)
			? $past(bank_select_shadow_q) : $past(bank_q)));
	endproperty
	a_fast_restore: assert property (p_fast_restore)
		else $error("shadow restore wrong for fast bit");
	property p_literal_return;
		@(posedge clk) disable iff (rst)
		do_return_with_literal |=> (work_q == $past(lit_q)) && (pc_q == $past(top_of_return_stack))
			&& $stable(pc_latch_high_q) && $stable(pc_latch_upper_q);
	endproperty
	a_literal_return: assert property (p_literal_return)
		else $error("literal return result wrong");
	property p_two_cycles;
		@(posedge clk) disable iff (rst)
		(issue && wop == 3'(OP_RETURN_WITH_LITERAL)) |=> busy [*8] ##1 !busy;
	endproperty
	a_two_cycles: assert property (p_two_cycles)
		else $error("literal return not two instruction cycles");
endmodule

`default_nettype wire

// >>> shared/call_return_reset_exec_regs.svh
// Register offsets, field positions, reset values and phase counts.
`ifndef CALL_RETURN_RESET_EXEC_REGS_SVH
`define CALL_RETURN_RESET_EXEC_REGS_SVH

`define CRX_ADDR_W        8
`define CRX_OFF_CTRL      8'h00
`define CRX_OFF_PC        8'h04
`define CRX_OFF_TARGET    8'h08
`define CRX_OFF_CORE      8'h0C
`define CRX_OFF_SHADOW    8'h10
`define CRX_OFF_LATCH     8'h14
`define CRX_OFF_STACK     8'h18

`define CRX_CTRL_OP_LSB   0
`define CRX_CTRL_FAST_BIT 3
`define CRX_CTRL_HIGH_BIT 4
`define CRX_CTRL_LIT_LSB  8
`define CRX_CORE_FLG_LSB  8
`define CRX_CORE_BSR_LSB  16
`define CRX_LATCH_UP_LSB  8
`define CRX_LATCH_GIEH    16
`define CRX_LATCH_GIEL    17
`define CRX_STACK_PTR_LSB 24

`define CRX_RST_PC        21'h00_0000
`define CRX_RST_WORK      8'h00
`define CRX_RST_FLAGS     8'h00
`define CRX_RST_BANK      4'h0
`define CRX_RST_LATCH_HI  8'h00
`define CRX_RST_LATCH_UP  5'h00
`define CRX_RST_IRQ_EN    1'b0
`define CRX_RST_PTR       5'h00

`define CRX_PC_STEP       21'h00_0002
`define CRX_PHASE_PUSH    2'h1
`define CRX_PHASE_RESET   2'h1
`define CRX_PHASE_LAST    2'h3

`endif

// >>> shared/call_return_reset_exec_pkg.sv
// Types shared by the control-flow execution block.
package call_return_reset_exec_pkg;
	typedef enum logic [2:0] {
		OP_NONE,
		OP_RESET,
		OP_RELATIVE_SUBROUTINE_CALL,
		OP_RETURN_FROM_IRQ,
		OP_RETURN_WITH_LITERAL
	} op_type;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_EXEC1,
		ST_EXEC2
	} state_type;
endpackage

// >>> testbench/call_return_reset_exec_tb.sv
// Self-checking testbench for the control-flow execution block.
`timescale 1ns/1ps
`default_nettype none
`include "call_return_reset_exec_regs.svh"

`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end

module call_return_reset_exec_tb;
	import call_return_reset_exec_pkg::*;

	logic        clk;
	logic        rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        busy;
	state_type   state;
	int          n_mismatch;
	int          cmp_count;
	int          n;
	logic [31:0] r;
	logic        e;
	logic [7:0]  row_addr [5];
	logic [31:0] row_mask [5];

	call_return_reset_exec u_dut (
		.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .busy(busy), .state(state)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ----------------------------------------
	// Bus tasks
	// ----------------------------------------
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] rd_data, output logic err);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd_data = prdata;
		err     = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		logic        y;
		apb(1'b1, a, d, x, y);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] x;
		logic        y;
		apb(1'b0, a, 32'h0000_0000, x, y);
		`CHK(x, exp)
	endtask

	// Counts the clocks for which busy stays high after an issue.
	task automatic wait_idle(output int cnt);
		cnt = 0;
		#1;
		while (busy === 1'b1 && cnt < 100) begin
			@(posedge clk);
			#1;
			cnt++;
		end
	endtask

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		#100000;
		n_mismatch++;
		print_verdict();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		n_mismatch = 0;
		cmp_count  = 0;
		rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 8'h00; pwdata = 32'h0000_0000;
		row_addr = '{`CRX_OFF_PC, `CRX_OFF_TARGET, `CRX_OFF_CORE,
			`CRX_OFF_SHADOW, `CRX_OFF_LATCH};
		row_mask = '{32'h001F_FFFF, 32'h001F_FFFF, 32'h000F_FFFF,
			32'h000F_FFFF, 32'h0003_1FFF};
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			rd(row_addr[i], 32'h0000_0000);
			wr(row_addr[i], 32'hFFFF_FFFF);
			rd(row_addr[i], row_mask[i]);
		end
		apb(1'b1, `CRX_OFF_STACK, 32'h0000_0001, r, e);
		`CHK(e, 1'b1)
		apb(1'b0, 8'h1C, 32'h0000_0000, r, e);
		`CHK({e, r}, {1'b1, 32'h0000_0000})
		// Relative call pushes the next word and jumps.
		wr(`CRX_OFF_PC, 32'h0000_0124);
		wr(`CRX_OFF_TARGET, 32'h0000_3458);
		wr(`CRX_OFF_CORE, 32'h0003_2211);
		wr(`CRX_OFF_LATCH, 32'h0000_1234);
		wr(`CRX_OFF_CTRL, 32'h0000_0002);
		wait_idle(n);
		`CHK(n, 8)
		rd(`CRX_OFF_STACK, 32'h0100_0126);
		rd(`CRX_OFF_PC, 32'h0000_3458);
		// Return with literal.
		wr(`CRX_OFF_CTRL, 32'h0000_A504);
		wait_idle(n);
		`CHK(n, 8)
		rd(`CRX_OFF_PC, 32'h0000_0126);
		rd(`CRX_OFF_CORE, 32'h0003_22A5);
		rd(`CRX_OFF_LATCH, 32'h0000_1234);
		rd(`CRX_OFF_STACK, 32'h0000_0000);
		// Fast return from a high-priority interrupt.
		wr(`CRX_OFF_PC, 32'h0000_0200);
		wr(`CRX_OFF_TARGET, 32'h0000_0400);
		wr(`CRX_OFF_CTRL, 32'h0000_0002);
		wait_idle(n);
		wr(`CRX_OFF_SHADOW, 32'h000C_BB66);
		wr(`CRX_OFF_CTRL, 32'h0000_001B);
		wait_idle(n);
		rd(`CRX_OFF_PC, 32'h0000_0202);
		rd(`CRX_OFF_STACK, 32'h0000_0000);
		rd(`CRX_OFF_CORE, 32'h000C_BB66);
		rd(`CRX_OFF_LATCH, 32'h0001_1234);
		// Writes during execution are refused; plain low-priority return.
		wr(`CRX_OFF_SHADOW, 32'h0001_0101);
		wr(`CRX_OFF_PC, 32'h0000_0300);
		wr(`CRX_OFF_CTRL, 32'h0000_0002);
		apb(1'b1, `CRX_OFF_PC, 32'h0000_0555, r, e);
		`CHK(e, 1'b1)
		apb(1'b0, `CRX_OFF_CTRL, 32'h0000_0000, r, e);
		`CHK(r[0], 1'b1)
		wait_idle(n);
		rd(`CRX_OFF_PC, 32'h0000_0400);
		rd(`CRX_OFF_STACK, 32'h0100_0302);
		wr(`CRX_OFF_CTRL, 32'h0000_0003);
		wait_idle(n);
		rd(`CRX_OFF_PC, 32'h0000_0302);
		rd(`CRX_OFF_CORE, 32'h000C_BB66);
		rd(`CRX_OFF_LATCH, 32'h0003_1234);
		rd(`CRX_OFF_STACK, 32'h0000_0000);
		// Software reset clears all registers and empties the stack by resetting its pointer.
		wr(`CRX_OFF_CTRL, 32'h0000_0002);
		wait_idle(n);
		wr(`CRX_OFF_CTRL, 32'h0000_0001);
		wait_idle(n);
		`CHK(n, 4)
		for (int i = 0; i < 5; i++)
			rd(row_addr[i], 32'h0000_0000);
		rd(`CRX_OFF_STACK, 32'h0000_0000);
		// Pin reset in mid-instruction returns to idle.
		wr(`CRX_OFF_CTRL, 32'h0000_0002);
		@(posedge clk);
		rst <= 1'b1;
		@(posedge clk);
		#1;
		`CHK({busy, state}, {1'b0, ST_IDLE})
		@(posedge clk);
		rst <= 1'b0;
		rd(`CRX_OFF_PC, 32'h0000_0000);
		print_verdict();
	end
endmodule

`default_nettype wire
